//--- smbus_map.svh
`ifndef SMBUS_MAP_SVH
`define SMBUS_MAP_SVH

// Register byte addresses on the APB bus.
`define CFG_ADDR        12'h000
`define CTL_ADDR        12'h004
`define DAT_ADDR        12'h008

// Configuration field positions.
`define CFG_ENABLE_BIT  7
`define CFG_INHIBIT_BIT 6
`define CFG_BUSY_BIT    5
`define CFG_TOE_BIT     3
`define CFG_FTE_BIT     2
`define CFG_CS_LSB      0

// Control and status field positions.
`define CTL_MASTER_BIT  7
`define CTL_TXMODE_BIT  6
`define CTL_START_BIT   5
`define CTL_STOP_BIT    4
`define CTL_ACKRQ_BIT   3
`define CTL_ARBLOST_BIT 2
`define CTL_ACK_BIT     1
`define CTL_EVENT_BIT   0

// Reset values.
`define CFG_RESET       8'h00
`define CTL_RESET       8'h00

// Bus-free timeout in selected clock source periods (more than this many).
`define FREE_PERIODS    4'hA
// Smallest system clocks per SCL phase so the bit rate stays at or below a tenth of the clock.
`define MIN_PHASE_CLKS  4'h5

`endif

//--- smbus_pkg.sv
`default_nettype none
package smbus_pkg;

  // Byte-engine states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_LOW,
    ST_HIGH,
    ST_WAIT,
    ST_STOP
  } engine_e;

  // Open-drain pin outputs: enable low means pulling the wire low.
  typedef struct packed {
    logic scl_oe_n;
    logic sda_oe_n;
  } pin_drive_s;

  // Bus conditions seen on the pins.
  typedef struct packed {
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
  } bus_event_s;

endpackage : smbus_pkg
`default_nettype wire

//--- two_wire_smbus_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "smbus_map.svh"

module two_wire_smbus_controller
  import smbus_pkg::*;
(
  input  wire logic        clk_sys,       // System clock, 100 MHz.
  input  wire logic        reset,         // Synchronous reset, active high.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB access phase.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [11:0] paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error on unmapped address.
  input  wire logic [3:0]  timer_ovf,     // Overflow pulses of the four timers.
  input  wire logic        scl_i,         // SCL wire level.
  output logic             scl_o,         // SCL output value, always low.
  output logic             scl_oe_n,      // Low while pulling SCL low.
  input  wire logic        sda_i,         // SDA wire level.
  output logic             sda_o,         // SDA output value, always low.
  output logic             sda_oe_n,      // Low while pulling SDA low.
  output logic             timer_reload   // Holds the timeout timer in reload.
);

  logic [7:0]  bus_config_register;
  logic [7:0]  bus_control_status_register;
  logic [7:0]  bus_shift_data_register;
  logic [1:0]  scl_sync_reg;
  logic [1:0]  sda_sync_reg;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        busy_reg;
  logic [3:0]  free_cnt_reg;
  logic [3:0]  phase_cnt_reg;
  logic [3:0]  bit_cnt_reg;
  logic        addr_phase_reg;
  logic        slave_active_reg;
  logic [6:0]  own_addr_reg;
  engine_e     state_reg;
  pin_drive_s  drive_reg;
  bus_event_s  ev;
  logic        scl_s;
  logic        sda_s;
  logic        tick;
  logic        apb_wr;
  logic        enabled;
  logic        master_mode;
  logic        tx_bit;
  logic        free_timeout;

  assign scl_s   = scl_sync_reg[1];
  assign sda_s   = sda_sync_reg[1];
  assign enabled = bus_config_register[`CFG_ENABLE_BIT];
  assign master_mode = bus_control_status_register[`CTL_MASTER_BIT];
  assign apb_wr  = psel & penable & pwrite;

  // Two flip-flops on each pin before any logic reads it.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // Bus condition detection on the synchronised levels.
  always_comb
  begin
    ev.start_seen = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    ev.stop_seen  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
    ev.scl_rise   = scl_s & ~scl_prev_reg;
    ev.scl_fall   = ~scl_s & scl_prev_reg;
  end

  assign tick = timer_ovf[bus_config_register[`CFG_CS_LSB +: 2]];

  // Counts source periods with both lines high; expiry frees the bus.
  // free timeout count
  always_ff @(posedge clk_sys)
  begin
    if (reset || !scl_s || !sda_s || !busy_reg)
      free_cnt_reg <= 4'h0;
    else if (tick && free_cnt_reg <= `FREE_PERIODS)
      free_cnt_reg <= free_cnt_reg + 4'h1;
  end
  assign free_timeout = bus_config_register[`CFG_FTE_BIT] && busy_reg && tick &&
                        (free_cnt_reg == `FREE_PERIODS);

  // Busy flag follows START, and clears on STOP or free timeout.
  // busy tracking
  always_ff @(posedge clk_sys)
  begin
    if (reset || !enabled)
      busy_reg <= 1'b0;
    else if (ev.start_seen || state_reg == ST_START)
      busy_reg <= 1'b1;
    else if (ev.stop_seen || free_timeout)
      busy_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      timer_reload <= 1'b1;
    else
      timer_reload <= !bus_config_register[`CFG_TOE_BIT] || scl_s;
  end

  // Configuration register; busy bit is read-only status.
  // configuration register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      bus_config_register <= `CFG_RESET;
    else if (apb_wr && paddr == `CFG_ADDR)
      bus_config_register <= {pwdata[7:6], 1'b0, pwdata[4:0]};
  end

  // Own slave address, taken from bits 15:9 of a config write.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      own_addr_reg <= 7'h00;
    else if (apb_wr && paddr == `CFG_ADDR)
      own_addr_reg <= pwdata[15:9];
  end

  // Bit to drive on SDA: shift data when transmitting, else acknowledge.
  always_comb
  begin
    if (bit_cnt_reg < 4'h8)
      tx_bit = bus_control_status_register[`CTL_TXMODE_BIT] ? bus_shift_data_register[7] : 1'b1;
    else
      tx_bit = bus_control_status_register[`CTL_TXMODE_BIT] ? 1'b1 : ~bus_control_status_register[`CTL_ACK_BIT];
  end

  // Byte engine: START, eight bits plus acknowledge, hand back to software, STOP.
  // master clocking
  always_ff @(posedge clk_sys)
  begin
    if (reset || !enabled)
    begin
      state_reg        <= ST_IDLE;
      drive_reg        <= '{scl_oe_n: 1'b1, sda_oe_n: 1'b1};
      phase_cnt_reg    <= 4'h0;
      bit_cnt_reg      <= 4'h0;
      addr_phase_reg   <= 1'b0;
      slave_active_reg <= 1'b0;
      bus_control_status_register <= `CTL_RESET;
      bus_shift_data_register     <= 8'h00;
    end
    else
    begin
      if (phase_cnt_reg != 4'h0)
        phase_cnt_reg <= phase_cnt_reg - 4'h1;
      // Software writes; an event set in the same cycle still wins below.
      if (apb_wr && paddr == `CTL_ADDR)
        bus_control_status_register <= {master_mode, pwdata[6:0]};
      if (apb_wr && paddr == `DAT_ADDR)
        bus_shift_data_register <= pwdata[7:0];
      if (free_timeout)
        bus_control_status_register[`CTL_STOP_BIT] <= 1'b1;
      // Slave wake-up on a START driven by another master.
      if (ev.start_seen && state_reg == ST_IDLE)
      begin
        state_reg        <= ST_LOW;
        bit_cnt_reg      <= 4'h0;
        addr_phase_reg   <= 1'b1;
        slave_active_reg <= 1'b1;
        bus_control_status_register[`CTL_TXMODE_BIT] <= 1'b0;
        bus_control_status_register[`CTL_ACK_BIT]    <= 1'b0;
      end
      // A STOP, or a free timeout standing in for one, returns a non-master engine to idle.
      if ((ev.stop_seen || free_timeout) && !master_mode)
      begin
        state_reg        <= ST_IDLE;
        slave_active_reg <= 1'b0;
        drive_reg        <= '{scl_oe_n: 1'b1, sda_oe_n: 1'b1};
        if (slave_active_reg || free_timeout)
          bus_control_status_register[`CTL_EVENT_BIT] <= 1'b1;
      end
      case (state_reg)
        ST_IDLE:
        begin
          if (bus_control_status_register[`CTL_START_BIT] && !busy_reg && !ev.start_seen)
          begin
            state_reg     <= ST_START;
            drive_reg.sda_oe_n <= 1'b0;
            phase_cnt_reg <= `MIN_PHASE_CLKS;
            bus_control_status_register[`CTL_MASTER_BIT] <= 1'b1;
            bus_control_status_register[`CTL_TXMODE_BIT] <= 1'b1;
          end
        end
        ST_START:
          if (phase_cnt_reg == 4'h0)
          begin
            drive_reg.scl_oe_n <= 1'b0;
            bus_control_status_register[`CTL_START_BIT] <= 1'b0;
            bus_control_status_register[`CTL_EVENT_BIT] <= 1'b1;
            // The next byte after our own START is the address byte.
            addr_phase_reg <= 1'b1;
            bit_cnt_reg   <= 4'h0;
            state_reg     <= ST_WAIT;
          end
        ST_LOW:
        begin
          // data change low
          // A master moves SDA mid-way through its low phase, clear of both clock edges.
          if (master_mode && phase_cnt_reg == 4'h2)
            drive_reg.sda_oe_n <= tx_bit;
          // A slave puts its bit out as soon as it sees the clock low.
          if (!scl_s && !master_mode)
          begin
            drive_reg.sda_oe_n <= tx_bit;
            state_reg          <= ST_HIGH;
          end
          else if (!scl_s && master_mode && phase_cnt_reg == 4'h0)
          begin
            drive_reg.scl_oe_n <= 1'b1;
            phase_cnt_reg      <= `MIN_PHASE_CLKS;
            state_reg          <= ST_HIGH;
          end
        end
        ST_HIGH:
        begin
          if (ev.scl_rise)
          begin
            phase_cnt_reg <= `MIN_PHASE_CLKS;
            if (master_mode && bit_cnt_reg < 4'h8 && bus_control_status_register[`CTL_TXMODE_BIT]
                && drive_reg.sda_oe_n && !sda_s)
            begin
              bus_control_status_register[`CTL_MASTER_BIT]  <= 1'b0;
              bus_control_status_register[`CTL_ARBLOST_BIT] <= 1'b1;
              bus_control_status_register[`CTL_TXMODE_BIT]  <= 1'b0;
              slave_active_reg   <= 1'b1;
              drive_reg.sda_oe_n <= 1'b1;
            end
            if (bit_cnt_reg < 4'h8)
              bus_shift_data_register <= {bus_shift_data_register[6:0], sda_s};
            else
              bus_control_status_register[`CTL_ACK_BIT] <= ~sda_s;
          end
          if ((master_mode && scl_s && phase_cnt_reg == 4'h1) || (!master_mode && ev.scl_fall))
          begin
            if (master_mode)
              drive_reg.scl_oe_n <= 1'b0;
            phase_cnt_reg <= `MIN_PHASE_CLKS;
            if (bit_cnt_reg == 4'h8)
            begin
              bit_cnt_reg <= 4'h0;
              if (addr_phase_reg && !master_mode)
              begin
                slave_active_reg <= !bus_config_register[`CFG_INHIBIT_BIT] &&
                                    bus_shift_data_register[7:1] == own_addr_reg;
                bus_control_status_register[`CTL_TXMODE_BIT] <= bus_shift_data_register[0];
              end
              else if (addr_phase_reg)
                bus_control_status_register[`CTL_TXMODE_BIT] <= ~bus_shift_data_register[0];
              addr_phase_reg <= 1'b0;
              bus_control_status_register[`CTL_EVENT_BIT] <= 1'b1;
              drive_reg.sda_oe_n <= 1'b1;
              if (!master_mode)
                drive_reg.scl_oe_n <= !slave_active_reg;
              state_reg <= ST_WAIT;
            end
            else
            begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              state_reg   <= ST_LOW;
            end
          end
        end
        ST_WAIT:
        begin
          if (apb_wr && paddr == `CTL_ADDR && !pwdata[`CTL_EVENT_BIT])
          begin
            if (master_mode && pwdata[`CTL_STOP_BIT])
            begin
              drive_reg.sda_oe_n <= 1'b0;
              state_reg <= ST_STOP;
            end
            else if (master_mode || slave_active_reg)
            begin
              drive_reg.scl_oe_n <= master_mode ? 1'b0 : 1'b1;
              state_reg <= ST_LOW;
            end
            else
              state_reg <= ST_IDLE;
            phase_cnt_reg <= `MIN_PHASE_CLKS;
          end
        end
        ST_STOP:
        begin
          if (phase_cnt_reg == 4'h0 && !drive_reg.scl_oe_n)
          begin
            drive_reg.scl_oe_n <= 1'b1;
            phase_cnt_reg      <= `MIN_PHASE_CLKS;
          end
          else if (phase_cnt_reg == 4'h0 && scl_s)
          begin
            drive_reg.sda_oe_n <= 1'b1;
            bus_control_status_register[`CTL_MASTER_BIT] <= 1'b0;
            bus_control_status_register[`CTL_STOP_BIT]   <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Pins are driven only low; the enables come straight from flip-flops.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
    end
    else
    begin
      scl_oe_n <= drive_reg.scl_oe_n;
      sda_oe_n <= drive_reg.sda_oe_n;
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
    end
  end

  // APB slave: one-cycle access phase, error on unmapped address.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == `CFG_ADDR || paddr == `CTL_ADDR ||
                 paddr == `DAT_ADDR);
      case (paddr)
        `CFG_ADDR: prdata <= {16'h0000, own_addr_reg, 1'b0, bus_config_register[7:6], busy_reg,
                              bus_config_register[4:0]};
        `CTL_ADDR: prdata <= {24'h00_0000, bus_control_status_register};
        `DAT_ADDR: prdata <= {24'h00_0000, bus_shift_data_register};
        default:   prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : two_wire_smbus_controller
`default_nettype wire

//--- smbus_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "smbus_map.svh"
module smbus_monitor
(
  input wire logic        clk_sys,     // System clock.
  input wire logic        reset,       // Synchronous reset.
  input wire logic        psel,        // APB select.
  input wire logic        penable,     // APB access phase.
  input wire logic        pwrite,      // APB direction.
  input wire logic [11:0] paddr,       // APB address.
  input wire logic [31:0] pwdata,      // APB write data.
  input wire logic        pready,      // APB ready.
  input wire logic        pslverr,     // APB error.
  input wire logic        scl_i,       // SCL wire.
  input wire logic        scl_o,       // SCL value.
  input wire logic        scl_oe_n,    // SCL pull.
  input wire logic        sda_o,       // SDA value.
  input wire logic        sda_oe_n,    // SDA pull.
  input wire logic        timer_reload // Timer reload.
);
  logic toe_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Shadow of the SCL timeout enable, taken at each completed config write.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      toe_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == `CFG_ADDR)
      toe_q <= pwdata[`CFG_TOE_BIT];
  end

  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  sequence s_scl_high; (toe_q && scl_i)[*5]; endsequence
  sequence s_scl_low; (toe_q && !scl_i)[*5]; endsequence

  property p_zero_wait; s_setup ##1 s_access |-> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_slverr; pready |-> pslverr == !(paddr == `CFG_ADDR || paddr == `CTL_ADDR || paddr == `DAT_ADDR);
  endproperty
  property p_pins_low; !scl_oe_n || !sda_oe_n |-> !scl_o && !sda_o; endproperty
  property p_reset_idle; $fell(reset) |-> scl_oe_n && sda_oe_n && timer_reload && !pready; endproperty
  property p_master_waits; scl_oe_n && !scl_i |=> scl_oe_n; endproperty
  property p_high_phase; $rose(scl_oe_n) |-> scl_oe_n[*5]; endproperty
  property p_low_phase; $fell(scl_oe_n) |-> (!scl_oe_n)[*5]; endproperty
  property p_reload_high; s_scl_high |-> timer_reload; endproperty
  property p_reload_low; s_scl_low |-> !timer_reload; endproperty

  a_zero_wait: assert property (p_zero_wait) else $error("access without ready");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  a_slverr: assert property (p_slverr) else $error("wrong error response");
  a_pins_low: assert property (p_pins_low) else $error("pin driven high");
  a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
  a_master_waits: assert property (p_master_waits) else $error("SCL pulled before rise");
  a_high_phase: assert property (p_high_phase) else $error("SCL high phase short");
  a_low_phase: assert property (p_low_phase) else $error("SCL low phase short");
  a_reload_high: assert property (p_reload_high) else $error("timer not reloaded");
  a_reload_low: assert property (p_reload_low) else $error("timer held in reload");
endmodule : smbus_monitor
`default_nettype wire

//--- smbus_target_model.sv
`timescale 1ns/100ps
`default_nettype none
module smbus_target_model
(
  input  wire logic       scl,        // SCL wire.
  input  wire logic       sda,        // SDA wire.
  input  wire logic [6:0] own_addr,   // Answered address.
  input  wire logic       stretch_on, // Stretch while driving ack.
  output logic            scl_n,      // Low pulls SCL.
  output logic            sda_n,      // Low pulls SDA.
  output logic [7:0]      last_byte,  // Last byte in.
  output logic            stop_seen   // STOP after START.
);
  logic       active = 1'b0;
  logic       first = 1'b0;
  logic       matched = 1'b0;
  logic [3:0] nbit = 4'h0;
  logic [7:0] shreg = 8'h00;

  // Lines start released so the pull-ups set the idle level.
  initial
  begin
    scl_n = 1'b1;
    sda_n = 1'b1;
    last_byte = 8'h00;
    stop_seen = 1'b0;
  end

  always @(negedge sda)
  begin
    if (scl)
    begin
      active = 1'b1;
      first = 1'b1;
      nbit = 4'h0;
      stop_seen = 1'b0;
    end
  end

  always @(posedge sda)
  begin
    if (scl)
    begin
      active = 1'b0;
      stop_seen = 1'b1;
    end
  end

  always @(posedge scl)
  begin
    if (active && nbit < 4'h8)
    begin
      shreg = {shreg[6:0], sda};
      nbit = nbit + 4'h1;
    end
  end

  // ack by pulling low, optional stretch
  always @(negedge scl)
  begin
    if (active && nbit == 4'h8)
    begin
      last_byte = shreg;
      if (first)
        matched = (shreg[7:1] == own_addr);
      first = 1'b0;
      nbit = 4'h9;
      sda_n = ~matched;
      if (stretch_on)
      begin
        scl_n = 1'b0;
        #300;
        scl_n = 1'b1;
      end
    end
    else if (active && nbit == 4'h9)
    begin
      sda_n = 1'b1;
      nbit = 4'h0;
    end
  end
endmodule : smbus_target_model
`default_nettype wire

//--- two_wire_smbus_controller_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "smbus_map.svh"
module two_wire_smbus_controller_tb_top;
  localparam logic [31:0] CF_EN = 32'h1 << `CFG_ENABLE_BIT;
  localparam logic [31:0] CF_FT = 32'h1 << `CFG_FTE_BIT;
  localparam logic [31:0] CF_TO = 32'h1 << `CFG_TOE_BIT;
  localparam logic [31:0] CT_TX = 32'h1 << `CTL_TXMODE_BIT;
  localparam logic [31:0] CT_STA = 32'h1 << `CTL_START_BIT;
  localparam logic [31:0] CT_STO = 32'h1 << `CTL_STOP_BIT;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  timer_ovf = 4'h0;
  logic        tb_scl_n = 1'b1;
  logic        tb_sda_n = 1'b1;
  logic        stretch_on = 1'b0;
  logic [31:0] prdata, rd_v;
  logic [7:0]  last_byte;
  logic        pready, pslverr, err_v, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic        timer_reload, slv_scl_n, slv_sda_n, stop_seen;
  int          fails = 0;
  int          n_checks = 0;
  // Open-drain wires with pull-ups: low while any party pulls.
  wire scl = scl_oe_n & slv_scl_n & tb_scl_n;
  wire sda = sda_oe_n & slv_sda_n & tb_sda_n;

  // System clock at 100 MHz.
  always #5 clk_sys = ~clk_sys;

  two_wire_smbus_controller dut
  (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_ovf(timer_ovf), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .timer_reload(timer_reload)
  );

  smbus_target_model target
  (
    .scl(scl), .sda(sda), .own_addr(7'h5A), .stretch_on(stretch_on), .scl_n(slv_scl_n),
    .sda_n(slv_sda_n), .last_byte(last_byte), .stop_seen(stop_seen)
  );

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until ready is sampled high.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(pready, 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  // Overflow pulses on the given timer lines.
  task automatic ticks(input logic [3:0] m, input int n);
    repeat (n)
    begin
      timer_ovf <= m;
      @(posedge clk_sys);
      timer_ovf <= 4'h0;
      @(posedge clk_sys);
    end
  endtask : ticks

  // Another master issues a START, then leaves both lines high without a STOP.
  task automatic claim();
    tb_sda_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    tb_scl_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    tb_sda_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    tb_scl_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : claim

  // Polls the control register until the event flag rises.
  task automatic wait_evt();
    int n;
    n = 0;
    rd_v = 32'h0;
    while (rd_v[`CTL_EVENT_BIT] !== 1'b1 && n < 500)
    begin
      apb(`CTL_ADDR, 1'b0, 32'h0);
      n++;
    end
    chk(rd_v[`CTL_EVENT_BIT], 1'b1);
  endtask : wait_evt

  // Sends one byte and checks the acknowledge and what the target shifted in.
  task automatic send(input logic [7:0] b, input logic ack);
    apb(`DAT_ADDR, 1'b1, {24'h0, b});
    apb(`CTL_ADDR, 1'b1, CT_TX);
    wait_evt();
    chk(rd_v[`CTL_ACK_BIT], ack);
    chk(last_byte, b);
  endtask : send

  // Requests a STOP and waits for busy to clear.
  task automatic stop_bus();
    int n;
    n = 0;
    apb(`CTL_ADDR, 1'b1, CT_STO);
    rd_v = 32'hFFFFFFFF;
    while (rd_v[`CFG_BUSY_BIT] !== 1'b0 && n < 200)
    begin
      apb(`CFG_ADDR, 1'b0, 32'h0);
      n++;
    end
    chk(rd_v[`CFG_BUSY_BIT], 1'b0);
    chk(stop_seen, 1'b1);
  endtask : stop_bus

  // Prints the counts and the verdict, then ends the run.
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // Main sequence of tests.
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    apb(`CFG_ADDR, 1'b1, 32'h1 << `CFG_BUSY_BIT);
    chk(rd_v, 32'h0);
    apb(`CFG_ADDR, 1'b0, 32'h0);
    chk(rd_v, `CFG_RESET);
    apb(`CTL_ADDR, 1'b0, 32'h0);
    chk(rd_v, `CTL_RESET);
    apb(12'h00C, 1'b0, 32'h0);
    chk({rd_v[30:0], err_v}, 32'h1);
    $display("Test registers done");
    for (int s = 0; s < 4; s++)
    begin
      apb(`CFG_ADDR, 1'b1, CF_EN | CF_FT | 32'(s));
      apb(`CTL_ADDR, 1'b1, 32'h0);
      claim();
      ticks(4'h1 << ((s + 1) % 4), 12);
      ticks(4'h1 << s, 10);
      apb(`CFG_ADDR, 1'b0, 32'h0);
      chk(rd_v[`CFG_BUSY_BIT], 1'b1);
      ticks(4'h1 << s, 1);
      apb(`CFG_ADDR, 1'b0, 32'h0);
      chk(rd_v[`CFG_BUSY_BIT], 1'b0);
      apb(`CTL_ADDR, 1'b0, 32'h0);
      chk(rd_v[`CTL_STOP_BIT], 1'b1);
    end
    $display("Test free timeout done");
    apb(`CFG_ADDR, 1'b1, CF_EN | CF_FT | CF_TO);
    claim();
    apb(`CTL_ADDR, 1'b1, CT_STA);
    repeat (20) @(posedge clk_sys);
    chk(sda_oe_n, 1'b1);
    ticks(4'h1, 11);
    // The timeout raises its own event; let the START finish before polling.
    repeat (10) @(posedge clk_sys);
    wait_evt();
    chk(rd_v[`CTL_MASTER_BIT], 1'b1);
    send(8'hB4, 1'b1);
    stretch_on <= 1'b1;
    send(8'hC3, 1'b1);
    stop_bus();
    $display("Test master write done");
    stretch_on <= 1'b0;
    apb(`CTL_ADDR, 1'b1, CT_STA);
    wait_evt();
    send(8'h6A, 1'b0);
    stop_bus();
    $display("Test not acknowledged done");
    end_sim();
  end

  // Cuts the run short if a wait hangs.
  initial
  begin
    #500000;
    fails++;
    end_sim();
  end
endmodule : two_wire_smbus_controller_tb_top

bind two_wire_smbus_controller smbus_monitor mon
(
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .timer_reload(timer_reload)
);
`default_nettype wire
